// ---- bench/dchsp_psi5_rx.sv ----
`timescale 1ns/100ps
module dchsp_psi5_rx (
    input wire logic  clk,
    input wire logic  psi5_tx,
    output logic [19:0] word,
    output logic [7:0]  frames,
    output logic        bad
);
    logic first;

    // frame decode: mid-point of each half, bad if a bit lacks its transition
    initial begin
        word = 20'h00000;
        frames = 8'h00;
        bad = 1'b0;
        forever begin
            @(posedge psi5_tx);
            for (int i = 0; i < 20; i++) begin
                repeat (i == 0 ? 80 : 160) @(posedge clk);
                first = psi5_tx;
                repeat (160) @(posedge clk);
                if (first === psi5_tx)
                    bad = 1'b1;
                word = {word[18:0], psi5_tx};
            end
            frames = frames + 8'h01;
        end
    end
endmodule

// ---- bench/dchsp_signal_path_monitor.sv ----
`timescale 1ns/100ps
module dchsp_signal_path_monitor #(
    parameter int FRAME_CYCLES  = 8000,
    parameter int WINDOW_CYCLES = 200
) (
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        sub_adc_valid,
    input wire logic [4:0]  sub_mux_sel,
    input wire logic        psi5_tx,
    input wire logic        prog_activate,
    input wire logic        prog_rd_req,
    input wire logic        prog_wr_req,
    input wire logic [7:0]  prog_wr_addr,
    input wire logic [15:0] prog_wr_data,
    input wire logic        prog_mode,
    input wire logic        prog_rd_valid,
    input wire logic        nvm_wr_en,
    input wire logic [7:0]  nvm_wr_addr,
    input wire logic [15:0] nvm_wr_data
);
    localparam int HALF = dchsp_pkg::PSI5_HALF_CYC;
    logic [15:0] hi_run;
    logic [23:0] age;

    // length of the present high stretch; a glitch on the line shows as a short run
    always_ff @(posedge clk or posedge rst) begin
        if (rst)
            hi_run <= 16'h0000;
        else
            hi_run <= psi5_tx ? hi_run + 16'h0001 : 16'h0000;
    end

    // stops one past the window, never wraps
    always_ff @(posedge clk or posedge rst) begin
        if (rst)
            age <= 24'h000000;
        else if (age <= 24'(WINDOW_CYCLES))
            age <= age + 24'h000001;
    end

    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    sel_rotate_a: assert property (
        sub_adc_valid |=> $past(sub_mux_sel) == {sub_mux_sel[0], sub_mux_sel[4:1]})
        else $error("sub select did not rotate");
    sel_hold_a: assert property (
        !sub_adc_valid |=> $stable(sub_mux_sel)) else $error("sub select moved");
    mode_sticky_a: assert property (
        prog_mode |=> prog_mode) else $error("programming mode dropped");
    mode_cause_a: assert property (
        $rose(prog_mode) |-> $past(prog_activate)) else $error("mode without command");
    mode_late_a: assert property (
        age > 24'(WINDOW_CYCLES) |-> !$rose(prog_mode)) else $error("mode after window");
    rd_answer_a: assert property (
        prog_rd_req && prog_mode |=> prog_rd_valid) else $error("read not answered");
    rd_only_a: assert property (
        prog_rd_valid |-> $past(prog_rd_req) && $past(prog_mode)) else $error("stray read");
    wr_pass_a: assert property (
        prog_wr_req && prog_mode |=> nvm_wr_en && nvm_wr_addr == $past(prog_wr_addr)
            && nvm_wr_data == $past(prog_wr_data)) else $error("write not forwarded");
    half_bit_a: assert property (
        $fell(psi5_tx) |-> hi_run == HALF || hi_run == 2 * HALF) else $error("bad half bit");
endmodule

bind dchsp_signal_path dchsp_signal_path_monitor #(
    .FRAME_CYCLES(FRAME_CYCLES),
    .WINDOW_CYCLES(WINDOW_CYCLES)
) i_mon (.*);

// ---- bench/dchsp_signal_path_test.sv ----
`timescale 1ns/100ps
module dchsp_signal_path_test;
    logic clk = 1'b0, rst = 1'b1, main_adc_valid = 1'b0, sub_adc_valid = 1'b0;
    logic prog_activate = 1'b0, prog_rd_req = 1'b0, prog_wr_req = 1'b0, pc;
    logic psi5_tx, prog_mode, prog_rd_valid, nvm_wr_en, bad;
    logic [2:0] prog_rd_addr = 3'h0;
    logic [3:0] filt_main = 4'h0, filt_sub = 4'h0;
    logic [4:0] sub_mux_sel;
    logic [7:0] prog_wr_addr = 8'h5A, nvm_wr_addr, frames, nf;
    logic [15:0] prog_wr_data = 16'h1234, prog_rd_data, nvm_wr_data;
    logic [19:0] word;
    logic signed [15:0] main_adc_data = 16'h0000, sub_adc_data = 16'h0000, out_main, out_sub;
    logic signed [15:0] gain, zero_main, zero_sub, hi, lo, t0, tc1, tc2;
    logic signed [15:0] calibrated_field_value_main, calibrated_field_value_sub;
    logic signed [15:0] internal_temperature_value_main, internal_temperature_value_sub;
    int n_errors = 0, n_tests = 0;
    // rows: sample, gain, zero, clamp hi, clamp lo, tc1, tc2, expected output
    logic [0:7][15:0] rw [7] = '{128'h0100_1000_0000_7FFF_8000_0000_0000_0100,
        128'h0100_2000_0010_7FFF_8000_0000_0000_0210, 128'h0800_1000_0000_0400_8000_0000_0000_0400,
        128'hF000_1000_0000_7FFF_F800_0000_0000_F800, 128'h7000_2000_1000_7FFF_8000_0000_0000_7FFF,
        128'h0100_1000_0000_7FFF_8000_2000_1000_01C0, 128'h9000_2000_F000_7FFF_8000_0000_0000_8000};
    logic [15:0] rd_exp [6] = '{16'h9000, 16'h9000, 16'h0000, 16'h0000, 16'h8000, 16'h8000};

    // both channels share most settings so every port still sees real values
    dchsp_signal_path #(.FRAME_CYCLES(8000), .WINDOW_CYCLES(200)) i_dut (.*,
        .gain_main(gain), .gain_sub(gain), .clamp_hi_main(hi), .clamp_hi_sub(hi),
        .clamp_lo_main(lo), .clamp_lo_sub(lo), .t0_main(t0), .t0_sub(t0),
        .tc1_main(tc1), .tc1_sub(tc1), .tc2_main(tc2), .tc2_sub(tc2));
    dchsp_psi5_rx i_rx (.*);

    always #12.5 clk = ~clk;

    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic summarize();
        $display("checks %0d errors %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic do_reset();
        rst <= 1'b1;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        #1;
        chk("sub_mux_sel", sub_mux_sel, 5'h01);
        chk("prog_mode", prog_mode, 1'b0);
        chk("out_main", out_main, 16'h0000);
    endtask

    // one main sample and a full five-step sub sequence, then settle
    task automatic run(input logic [15:0] xm, input logic [15:0] xs, input logic [15:0] tm,
                       input logic [15:0] ts);
        @(posedge clk);
        main_adc_valid <= 1'b1;
        main_adc_data <= xm;
        sub_adc_valid <= 1'b1;
        sub_adc_data <= xs;
        @(posedge clk);
        main_adc_valid <= 1'b0;
        sub_adc_data <= tm;
        @(posedge clk);
        sub_adc_data <= ts;
        @(posedge clk);
        sub_adc_data <= 16'h0000;
        repeat (2) @(posedge clk);
        sub_adc_valid <= 1'b0;
        repeat (4) @(posedge clk);
        #1;
    endtask

    task automatic req_rd(input logic [2:0] a, input logic v, input logic [15:0] d);
        @(posedge clk);
        prog_rd_req <= 1'b1;
        prog_rd_addr <= a;
        @(posedge clk);
        prog_rd_req <= 1'b0;
        #1;
        chk("prog_rd_valid", prog_rd_valid, v);
        if (v)
            chk("prog_rd_data", prog_rd_data, d);
    endtask

    task automatic act(input logic v);
        @(posedge clk);
        prog_activate <= 1'b1;
        @(posedge clk);
        prog_activate <= 1'b0;
        @(posedge clk);
        #1;
        chk("prog_mode", prog_mode, v);
    endtask

    initial begin
        {gain, zero_main, zero_sub, hi, lo, t0, tc1, tc2} = '0;
        do_reset();
        req_rd(3'h4, 1'b0, 16'h0000);
        act(1'b1);
        @(posedge clk);
        prog_wr_req <= 1'b1;
        @(posedge clk);
        prog_wr_req <= 1'b0;
        #1;
        chk("nvm_wr", {nvm_wr_en, nvm_wr_addr}, 9'h15A);
        chk("nvm_wr_data", nvm_wr_data, 16'h1234);
        t0 <= 16'hC000;
        for (int i = 0; i < 7; i++) begin
            {gain, zero_main, zero_sub, hi, lo} <= {rw[i][1], rw[i][2], rw[i][2:4]};
            {tc1, tc2} <= {rw[i][5], rw[i][6]};
            run(rw[i][0], rw[i][0], 16'h0000, 16'h0000);
            chk("cal_main", calibrated_field_value_main, rw[i][0]);
            chk("cal_sub", calibrated_field_value_sub, rw[i][0]);
            chk("out_main", out_main, rw[i][7]);
            chk("out_sub", out_sub, rw[i][7]);
        end
        for (int a = 0; a < 6; a++)
            req_rd(a[2:0], 1'b1, rd_exp[a]);
        filt_main <= 4'h1;
        zero_main <= 16'h0000;
        run(16'h0000, 16'h9000, 16'h0000, 16'h0000);
        chk("cal_main", calibrated_field_value_main, 16'hC800);
        chk("cal_sub", calibrated_field_value_sub, 16'h9000);
        for (int f = 0; f < 3; f++) begin
            nf = frames;
            for (int k = 0; k < 16000 && frames === nf; k++)
                @(negedge clk);
            if (frames === nf) begin
                n_errors++;
                summarize();
            end
            if (f > 0) begin
                chk("psi5_data", word[16:1], word[17] ? 16'h8000 : 16'h9000);
                chk("psi5_head", {word[19:18], ^word[17:0], bad}, 4'h0);
                chk("psi5_chan", word[17], !pc);
            end
            pc = word[17];
        end
        run(16'h0000, 16'h0000, 16'h0123, 16'h0456);
        chk("temp_main", internal_temperature_value_main, 16'h0123);
        chk("temp_sub", internal_temperature_value_sub, 16'h0456);
        req_rd(3'h3, 1'b1, 16'h0456);
        do_reset();
        repeat (210) @(posedge clk);
        act(1'b0);
        req_rd(3'h0, 1'b0, 16'h0000);
        summarize();
    end
endmodule

// ---- hw/dchsp_signal_path.sv ----
`timescale 1ns/100ps
module dchsp_signal_path #(
    parameter int FRAME_CYCLES = dchsp_pkg::FRAME_CYC,
    parameter int WINDOW_CYCLES = dchsp_pkg::PROG_WIN_CYC
) (
    input  wire logic                        clk,
    input  wire logic                        rst,
    // converters
    input  wire logic                        main_adc_valid,
    input  wire logic signed [15:0]          main_adc_data,
    input  wire logic                        sub_adc_valid,
    input  wire logic signed [15:0]          sub_adc_data,
    output logic [4:0]                       sub_mux_sel,
    // nonvolatile settings, main then sub
    input  wire logic [3:0]                  filt_main,
    input  wire logic [3:0]                  filt_sub,
    input  wire logic signed [15:0]          gain_main,
    input  wire logic signed [15:0]          gain_sub,
    input  wire logic signed [15:0]          zero_main,
    input  wire logic signed [15:0]          zero_sub,
    input  wire logic signed [15:0]          clamp_hi_main,
    input  wire logic signed [15:0]          clamp_lo_main,
    input  wire logic signed [15:0]          clamp_hi_sub,
    input  wire logic signed [15:0]          clamp_lo_sub,
    input  wire logic signed [15:0]          t0_main,
    input  wire logic signed [15:0]          t0_sub,
    input  wire logic signed [15:0]          tc1_main,
    input  wire logic signed [15:0]          tc1_sub,
    input  wire logic signed [15:0]          tc2_main,
    input  wire logic signed [15:0]          tc2_sub,
    // readable results
    output logic signed [15:0]               calibrated_field_value_main,
    output logic signed [15:0]               calibrated_field_value_sub,
    output logic signed [15:0]               internal_temperature_value_main,
    output logic signed [15:0]               internal_temperature_value_sub,
    output logic signed [15:0]               out_main,
    output logic signed [15:0]               out_sub,
    // psi5 line
    output logic                             psi5_tx,
    // decoded programming_serial_interface requests
    input  wire logic                        prog_activate,
    input  wire logic                        prog_rd_req,
    input  wire logic [2:0]                  prog_rd_addr,
    input  wire logic                        prog_wr_req,
    input  wire logic [7:0]                  prog_wr_addr,
    input  wire logic [15:0]                 prog_wr_data,
    output logic                             prog_mode,
    output logic                             prog_rd_valid,
    output logic [15:0]                      prog_rd_data,
    output logic                             nvm_wr_en,
    output logic [7:0]                       nvm_wr_addr,
    output logic [15:0]                      nvm_wr_data
);

    // ----------------------------------------------------------------
    // arithmetic helpers
    // ----------------------------------------------------------------
    // saturate to 16 bits so later stages never see a wrapped value
    function automatic logic signed [15:0] sat16(input logic signed [63:0] v);
        logic signed [15:0] r;
        r = v[15:0];
        if (v > dchsp_pkg::SAT_MAX) begin
            r = dchsp_pkg::SAT_MAX[15:0];
        end else if (v < dchsp_pkg::SAT_MIN) begin
            r = dchsp_pkg::SAT_MIN[15:0];
        end
        return r;
    endfunction

    // first-order low-pass, cutoff falls as k rises
    function automatic logic signed [23:0] lp_step(input logic signed [23:0] y,
                                                   input logic signed [15:0] x,
                                                   input logic [3:0] k);
        logic signed [24:0] diff;
        diff = {x[15], x, 8'h00} - {y[23], y};
        return 24'(25'(y) + (diff >>> k));
    endfunction

    // stress and temperature drift correction
    function automatic logic signed [15:0] drift_fix(input logic signed [15:0] f,
                                                     input logic signed [15:0] s,
                                                     input logic signed [15:0] t);
        logic signed [63:0] acc;
        acc = 64'(f) - ((64'(s) * 64'(dchsp_pkg::STRESS_COEF)) >>> dchsp_pkg::COMP_Q)
            - (((64'(t) - 64'(dchsp_pkg::TEMP_REF)) * 64'(dchsp_pkg::TEMP_COEF))
               >>> dchsp_pkg::COMP_Q);
        return sat16(acc);
    endfunction

    // gain, magnet polynomial, zero point and clamp for one channel
    function automatic logic signed [15:0] chan_out(input logic signed [15:0] cal,
                                                    input logic signed [15:0] t,
                                                    input logic signed [15:0] gain,
                                                    input logic signed [15:0] t0,
                                                    input logic signed [15:0] tc1,
                                                    input logic signed [15:0] tc2,
                                                    input logic signed [15:0] zero,
                                                    input logic signed [15:0] hi,
                                                    input logic signed [15:0] lo);
        logic signed [63:0] dt;
        logic signed [63:0] poly;
        logic signed [15:0] g;
        logic signed [15:0] s;
        logic signed [15:0] z;
        dt = 64'(t) - 64'(t0);
        poly = dchsp_pkg::POLY_ONE + ((64'(tc1) * dt) >>> dchsp_pkg::TC_Q)
             + ((64'(tc2) * dt * dt) >>> (2 * dchsp_pkg::TC_Q));
        g = sat16((64'(cal) * 64'(gain)) >>> dchsp_pkg::GAIN_Q);
        s = sat16((64'(g) * poly) >>> dchsp_pkg::POLY_Q);
        z = sat16(64'(s) + 64'(zero));
        if (z > hi) begin
            z = hi;
        end else if (z < lo) begin
            z = lo;
        end
        return z;
    endfunction

    // ----------------------------------------------------------------
    // sub converter sequencing
    // ----------------------------------------------------------------
    dchsp_pkg::dchsp_seq_t seq;
    dchsp_pkg::dchsp_seq_t next_seq;
    logic signed [15:0]    stress_main;
    logic signed [15:0]    stress_sub;

    always_comb begin
        unique case (seq)
            dchsp_pkg::SEQ_SUB_FIELD: next_seq = dchsp_pkg::SEQ_MAIN_TEMP;
            dchsp_pkg::SEQ_MAIN_TEMP: next_seq = dchsp_pkg::SEQ_SUB_TEMP;
            dchsp_pkg::SEQ_SUB_TEMP:  next_seq = dchsp_pkg::SEQ_MAIN_STR;
            dchsp_pkg::SEQ_MAIN_STR:  next_seq = dchsp_pkg::SEQ_SUB_STR;
            dchsp_pkg::SEQ_SUB_STR:   next_seq = dchsp_pkg::SEQ_SUB_FIELD;
            default:                  next_seq = dchsp_pkg::SEQ_SUB_FIELD;
        endcase
    end
    assign sub_mux_sel = seq;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            seq <= dchsp_pkg::SEQ_SUB_FIELD;
            internal_temperature_value_main <= '0;
            internal_temperature_value_sub <= '0;
            stress_main <= '0;
            stress_sub <= '0;
        end else if (sub_adc_valid) begin
            seq <= next_seq;
            if (seq == dchsp_pkg::SEQ_MAIN_TEMP) internal_temperature_value_main <= sub_adc_data;
            if (seq == dchsp_pkg::SEQ_SUB_TEMP)  internal_temperature_value_sub <= sub_adc_data;
            if (seq == dchsp_pkg::SEQ_MAIN_STR)  stress_main <= sub_adc_data;
            if (seq == dchsp_pkg::SEQ_SUB_STR)   stress_sub <= sub_adc_data;
        end
    end

    // ----------------------------------------------------------------
    // filtering, drift correction, output stage
    // ----------------------------------------------------------------
    logic signed [23:0] filt_acc_main;
    logic signed [23:0] filt_acc_sub;
    logic               cal_upd_main;
    logic               cal_upd_sub;
    logic               out_upd_main;
    logic               out_upd_sub;
    wire                sub_field_hit = sub_adc_valid && (seq == dchsp_pkg::SEQ_SUB_FIELD);

    // per-channel low-pass, one update per sample
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            filt_acc_main <= '0;
            filt_acc_sub <= '0;
        end else begin
            if (main_adc_valid) filt_acc_main <= lp_step(filt_acc_main, main_adc_data, filt_main);
            if (sub_field_hit)  filt_acc_sub <= lp_step(filt_acc_sub, sub_adc_data, filt_sub);
        end
    end

    // corrected field one cycle after the filter, output the cycle after
    // settings are nvm inputs, temperatures and stress from sensors
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cal_upd_main <= 1'b0;
            cal_upd_sub <= 1'b0;
            out_upd_main <= 1'b0;
            out_upd_sub <= 1'b0;
            calibrated_field_value_main <= '0;
            calibrated_field_value_sub <= '0;
            out_main <= '0;
            out_sub <= '0;
        end else begin
            cal_upd_main <= main_adc_valid;
            cal_upd_sub <= sub_field_hit;
            out_upd_main <= cal_upd_main;
            out_upd_sub <= cal_upd_sub;
            if (cal_upd_main) calibrated_field_value_main <= drift_fix(
                filt_acc_main[23:8], stress_main, internal_temperature_value_main);
            if (cal_upd_sub) calibrated_field_value_sub <= drift_fix(
                filt_acc_sub[23:8], stress_sub, internal_temperature_value_sub);
            if (out_upd_main) out_main <= chan_out(calibrated_field_value_main,
                internal_temperature_value_main, gain_main, t0_main, tc1_main, tc2_main,
                zero_main, clamp_hi_main, clamp_lo_main);
            if (out_upd_sub) out_sub <= chan_out(calibrated_field_value_sub,
                internal_temperature_value_sub, gain_sub, t0_sub, tc1_sub, tc2_sub,
                zero_sub, clamp_hi_sub, clamp_lo_sub);
        end
    end

    // ----------------------------------------------------------------
    // psi5 transmitter, frames alternate main and sub
    // ----------------------------------------------------------------
    dchsp_pkg::dchsp_tx_t tx_state;
    logic [23:0]          frame_cnt;
    logic [15:0]          half_cnt;
    logic [19:0]          tx_shift;
    logic [4:0]           bits_left;
    logic                 tx_half;
    logic                 tx_chan;
    wire                  frame_tick = (frame_cnt == 24'(FRAME_CYCLES - 1));
    wire                  half_done  = (half_cnt == 16'(dchsp_pkg::PSI5_HALF_CYC - 1));
    wire  [15:0]          tx_word    = tx_chan ? out_sub : out_main;
    // first start bit goes out first: it sits in the top bit
    wire  [19:0]          tx_frame   = {dchsp_pkg::START_BITS, tx_chan, tx_word,
                                        ^{tx_chan, tx_word}};

    // manchester, first half inverted, rising mid-bit means one
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tx_state <= dchsp_pkg::TX_IDLE;
            frame_cnt <= '0;
            half_cnt <= '0;
            tx_shift <= '0;
            bits_left <= '0;
            tx_half <= 1'b0;
            tx_chan <= 1'b0;
            psi5_tx <= 1'b0;
        end else begin
            frame_cnt <= frame_tick ? '0 : frame_cnt + 24'h000001;
            unique case (tx_state)
                dchsp_pkg::TX_IDLE: begin
                    psi5_tx <= 1'b0;
                    if (frame_tick) begin
                        tx_shift <= tx_frame;
                        bits_left <= 5'(dchsp_pkg::FRAME_BITS - 1);
                        tx_half <= 1'b0;
                        half_cnt <= '0;
                        psi5_tx <= ~tx_frame[19];
                        tx_state <= dchsp_pkg::TX_SEND;
                    end
                end
                dchsp_pkg::TX_SEND: begin
                    half_cnt <= half_done ? '0 : half_cnt + 16'h0001;
                    if (half_done && !tx_half) begin
                        tx_half <= 1'b1;
                        psi5_tx <= tx_shift[19];
                    end else if (half_done) begin
                        tx_half <= 1'b0;
                        if (bits_left == 5'h00) begin
                            psi5_tx <= 1'b0;
                            tx_chan <= ~tx_chan;
                            tx_state <= dchsp_pkg::TX_IDLE;
                        end else begin
                            tx_shift <= {tx_shift[18:0], 1'b0};
                            bits_left <= bits_left - 5'h01;
                            psi5_tx <= ~tx_shift[18];
                        end
                    end
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // programming access
    // ----------------------------------------------------------------
    logic [23:0] win_cnt;
    logic        win_open;
    logic [15:0] rd_mux;

    // window after reset, then closed for good
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            win_cnt <= '0;
            win_open <= 1'b1;
            prog_mode <= 1'b0;
        end else begin
            if (win_open) win_cnt <= win_cnt + 24'h000001;
            if (win_cnt == 24'(WINDOW_CYCLES - 1)) win_open <= 1'b0;
            if (prog_activate && win_open) prog_mode <= 1'b1;
        end
    end

    always_comb begin
        unique case (prog_rd_addr)
            dchsp_pkg::RA_CAL_MAIN:  rd_mux = calibrated_field_value_main;
            dchsp_pkg::RA_CAL_SUB:   rd_mux = calibrated_field_value_sub;
            dchsp_pkg::RA_TEMP_MAIN: rd_mux = internal_temperature_value_main;
            dchsp_pkg::RA_TEMP_SUB:  rd_mux = internal_temperature_value_sub;
            dchsp_pkg::RA_OUT_MAIN:  rd_mux = out_main;
            dchsp_pkg::RA_OUT_SUB:   rd_mux = out_sub;
            dchsp_pkg::RA_STR_MAIN:  rd_mux = stress_main;
            dchsp_pkg::RA_STR_SUB:   rd_mux = stress_sub;
        endcase
    end

    // reads and nvm writes only honoured in programming mode
    // one answer per request, the serial front end paces the bits
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            prog_rd_valid <= 1'b0;
            prog_rd_data <= '0;
            nvm_wr_en <= 1'b0;
            nvm_wr_addr <= '0;
            nvm_wr_data <= '0;
        end else begin
            prog_rd_valid <= prog_rd_req && prog_mode;
            nvm_wr_en <= prog_wr_req && prog_mode;
            if (prog_rd_req && prog_mode) prog_rd_data <= rd_mux;
            if (prog_wr_req && prog_mode) begin
                nvm_wr_addr <= prog_wr_addr;
                nvm_wr_data <= prog_wr_data;
            end
        end
    end

endmodule

// ---- shared/dchsp_pkg.sv ----
// Operation
// - main converter handles main field; sub converter is time-multiplexed over five inputs
// - each channel low-pass filters its field samples, cutoff set per channel
// - filtered field corrected for stress and temperature, held in readable register
// - main and sub temperature readings stored in per-channel temperature registers
// - each channel evaluates a configurable second-order magnet temperature polynomial
// - calibrated field multiplied by user gain and by the polynomial result
// - configured zero point offset added to the scaled field value
// - offset value clamped to per-channel limits and stored in output register
// - protocol frames built from main and sub outputs, sent on PSI5 pin
// - all processing settings come from nonvolatile memory plus acquired sensor data; stress and temperature drift trims are fixed in silicon instead
// - programming mode entered only when activate command arrives inside power-on window
// - programming interface writes nonvolatile memory and reads the calibrated, temperature, output and stress registers of both channels
package dchsp_pkg;

    // ----------------------------------------------------------------
    // data widths and fixed-point formats
    // ----------------------------------------------------------------
    localparam int DW        = 16;          // field, temperature and setting width
    localparam int FW        = 24;          // filter state width
    localparam int FRAC      = 8;           // filter state fraction bits
    localparam int KW        = 4;           // filter setting width
    localparam int GAIN_Q    = 12;          // gain fraction bits
    localparam int POLY_Q    = 14;          // polynomial fraction bits
    localparam int TC_Q      = 14;          // tc1/tc2 fraction bits
    localparam int COMP_Q    = 15;          // internal drift coefficient fraction bits
    localparam logic signed [63:0] POLY_ONE   = 64'sh0000_0000_0000_4000;
    localparam logic signed [63:0] SAT_MAX    = 64'sh0000_0000_0000_7FFF;
    localparam logic signed [63:0] SAT_MIN    = 64'shFFFF_FFFF_FFFF_8000;

    // internal drift trims, fixed in silicon
    localparam logic signed [DW-1:0] STRESS_COEF = 16'sh0100;
    localparam logic signed [DW-1:0] TEMP_COEF   = 16'sh0080;
    localparam logic signed [DW-1:0] TEMP_REF    = 16'sh0000;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS  = 25;
    localparam int PSI5_BIT_NS    = 8000;   // 125 kbit/s
    localparam int PSI5_HALF_CYC  = (PSI5_BIT_NS / 2) / CLK_PERIOD_NS;
    localparam int FRAME_US       = 500;
    localparam int FRAME_CYC      = FRAME_US * 1000 / CLK_PERIOD_NS;
    localparam int PROG_WIN_US    = 10000;
    localparam int PROG_WIN_CYC   = PROG_WIN_US * 1000 / CLK_PERIOD_NS;
    localparam int CNT_W          = 24;

    // ----------------------------------------------------------------
    // psi5 frame: 2 start bits, channel bit, 16 data bits, even parity
    // ----------------------------------------------------------------
    localparam int FRAME_BITS = 20;
    localparam logic [1:0] START_BITS = 2'h0;

    // ----------------------------------------------------------------
    // programming read map
    // ----------------------------------------------------------------
    localparam logic [2:0] RA_CAL_MAIN  = 3'h0;
    localparam logic [2:0] RA_CAL_SUB   = 3'h1;
    localparam logic [2:0] RA_TEMP_MAIN = 3'h2;
    localparam logic [2:0] RA_TEMP_SUB  = 3'h3;
    localparam logic [2:0] RA_OUT_MAIN  = 3'h4;
    localparam logic [2:0] RA_OUT_SUB   = 3'h5;
    localparam logic [2:0] RA_STR_MAIN  = 3'h6;
    localparam logic [2:0] RA_STR_SUB   = 3'h7;
    localparam int NVM_AW = 8;

    // sub converter input sequence, one-hot
    typedef enum logic [4:0] {
        SEQ_SUB_FIELD  = 5'h01,
        SEQ_MAIN_TEMP  = 5'h02,
        SEQ_SUB_TEMP   = 5'h04,
        SEQ_MAIN_STR   = 5'h08,
        SEQ_SUB_STR    = 5'h10
    } dchsp_seq_t;

    typedef enum logic [1:0] {
        TX_IDLE = 2'h1,
        TX_SEND = 2'h2
    } dchsp_tx_t;

endpackage
